// >>> hw/cfo_pkg.sv
// Constants shared by the option-byte loader and its helper modules.
// Assumes a single 250 MHz system clock and an 8-bit register port.
package cfo_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Option byte field positions.
  localparam int CFO_OPT_HALT_BIT = 0;
  localparam int CFO_OPT_PORTF_BIT = 1;
  localparam int CFO_OPT_SUP_BIT = 2;
  localparam int CFO_OPT_OSC_LO = 3;
  localparam int CFO_OPT_OSC_HI = 4;
  localparam int CFO_OPT_SEC_BIT = 5;
  localparam int CFO_OPT_POR_BIT = 6;

  // Oscillator select codes, as bits 4,3.
  localparam logic [1:0] CFO_OSC_EXT = 2'h0;
  localparam logic [1:0] CFO_OSC_RC = 2'h1;
  localparam logic [1:0] CFO_OSC_XTAL_NOBIAS = 2'h2;
  localparam logic [1:0] CFO_OSC_XTAL_BIAS = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices on the software port.
  localparam logic [4:0] CFO_IDX_STATUS_WORD = 5'h00;
  localparam logic [4:0] CFO_IDX_MAIN_CTRL = 5'h01;
  localparam logic [4:0] CFO_IDX_INT_CTRL = 5'h02;
  localparam logic [4:0] CFO_IDX_TMR2_CTRL = 5'h03;
  localparam logic [4:0] CFO_IDX_TMR3_CTRL = 5'h04;
  localparam logic [4:0] CFO_IDX_WAKE_EN = 5'h05;
  localparam logic [4:0] CFO_IDX_WAKE_EDGE = 5'h06;
  localparam logic [4:0] CFO_IDX_WAKE_PEND = 5'h07;
  localparam logic [4:0] CFO_IDX_SERIAL_SHIFT = 5'h08;
  localparam logic [4:0] CFO_IDX_BPTR = 5'h09;
  localparam logic [4:0] CFO_IDX_XPTR = 5'h0a;
  localparam logic [4:0] CFO_IDX_STACK_PTR = 5'h0b;
  localparam logic [4:0] CFO_IDX_ACCUM = 5'h0c;
  localparam logic [4:0] CFO_IDX_TIMER1 = 5'h0d;
  localparam logic [4:0] CFO_IDX_TIMER2 = 5'h0e;
  localparam logic [4:0] CFO_IDX_TIMER3 = 5'h0f;
  localparam logic [4:0] CFO_IDX_PC_LO = 5'h10;
  localparam logic [4:0] CFO_IDX_PC_HI = 5'h11;
  localparam logic [4:0] CFO_IDX_INIT_STATUS = 5'h12;
  localparam int CFO_NREG = 18;

  // Values loaded during initialization.
  localparam logic [7:0] CFO_SP_RESET = 8'h6f;
  localparam logic [7:0] CFO_CLEAR_VAL = 8'h00;
  localparam logic [15:0] CFO_LFSR_SEED = 16'hace1;
  localparam logic [3:0] CFO_INIT_MIN_CYC = 4'h3;

  // How each register behaves while initialization runs.
  typedef enum logic [2:0] {
    CFO_CLS_CLEAR,
    CFO_CLS_KEEP,
    CFO_CLS_XRND,
    CFO_CLS_RAND,
    CFO_CLS_SP
  } cfo_cls_t;

  function automatic cfo_cls_t cfo_class(input logic [4:0] idx);
    cfo_cls_t c;
    c = CFO_CLS_CLEAR;
    case (idx)
      CFO_IDX_WAKE_PEND: c = CFO_CLS_RAND;
      CFO_IDX_SERIAL_SHIFT, CFO_IDX_BPTR, CFO_IDX_XPTR: c = CFO_CLS_KEEP;
      CFO_IDX_ACCUM, CFO_IDX_TIMER1, CFO_IDX_TIMER2,
      CFO_IDX_TIMER3: c = CFO_CLS_XRND;
      CFO_IDX_STACK_PTR: c = CFO_CLS_SP;
      default: c = CFO_CLS_CLEAR;
    endcase
    return c;
  endfunction

endpackage

// >>> hw/cfo_sync.sv
// Two-flop synchroniser, one stage pair per bit.
// Assumes inputs arrive from pins outside the system clock domain.
module cfo_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;

  ////////////////////////////////////////////////////////////////////////////
  // Only the second stage is ever read by other logic.
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          stage1_r[b] <= RESET_VAL[b];
          syncOut[b] <= RESET_VAL[b];
        end else if (clkEn) begin
          stage1_r[b] <= asyncIn[b];
          syncOut[b] <= stage1_r[b];
        end
      end
    end
  endgenerate

endmodule

// >>> hw/cfo_option_decode.sv
// Combinational decode of the latched option byte into mode controls.
// Assumes the caller registers every result before it leaves the block.
module cfo_option_decode (
  input wire logic [7:0] optByte,
  output logic isXtal,
  output logic biasOn,
  output logic pinAsInput,
  output logic haltPermit,
  output logic supervisorOn,
  output logic portFFull,
  output logic porOn
);

  wire logic [1:0] oscSel;

  assign oscSel = optByte[cfo_pkg::CFO_OPT_OSC_HI:cfo_pkg::CFO_OPT_OSC_LO];
  assign isXtal = (oscSel == cfo_pkg::CFO_OSC_XTAL_NOBIAS) ||
                  (oscSel == cfo_pkg::CFO_OSC_XTAL_BIAS);
  assign biasOn = (oscSel == cfo_pkg::CFO_OSC_XTAL_BIAS);
  assign pinAsInput = (oscSel == cfo_pkg::CFO_OSC_RC) ||
                      (oscSel == cfo_pkg::CFO_OSC_EXT);
  assign haltPermit = !optByte[cfo_pkg::CFO_OPT_HALT_BIT];
  assign supervisorOn = !optByte[cfo_pkg::CFO_OPT_SUP_BIT];
  assign portFFull = !optByte[cfo_pkg::CFO_OPT_PORTF_BIT];
  assign porOn = optByte[cfo_pkg::CFO_OPT_POR_BIT];

endmodule

// >>> hw/cfo_loader.sv
// Option byte loader and reset-time initializer of the core state.
// Assumes the option byte arrives from factory fuses as static pins and
// that the power-on detector and reset pin are asynchronous to sys_clk.
module cfo_loader #(
  parameter int ADDR_W = 5
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [7:0] optFusePins,
  input wire logic extResetPin_n,
  input wire logic porDetectPin,
  input wire logic oscSharedPinIn,
  input wire logic haltReq,
  input wire logic supervisorErr,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  output logic initActive,
  output logic oscRcSel,
  output logic xtalEnable,
  output logic biasResEnable,
  output logic oscPinOe,
  output logic haltRestartIn,
  output logic haltEnter,
  output logic supervisorEnable,
  output logic supErrPinOut,
  output logic supErrPinOe,
  output logic portFOutEn,
  output logic portFPullEn,
  output logic portLcgfRelease,
  output logic portDForceHigh
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  wire logic [7:0] optSync;
  wire logic extRstSync_n;
  wire logic porSync;
  wire logic oscPinSync;

  cfo_sync #(.WIDTH(8), .RESET_VAL(8'h00)) u_optSync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .asyncIn(optFusePins),
    .syncOut(optSync)
  );

  cfo_sync #(.WIDTH(3), .RESET_VAL(3'h1)) u_pinSync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .asyncIn({oscSharedPinIn, porDetectPin, extResetPin_n}),
    .syncOut({oscPinSync, porSync, extRstSync_n})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Option byte latch. It has no register address at all, so software can
  // neither observe nor alter it; it only follows the fuses during init.
  logic [7:0] optLatched_r;
  logic [7:0] optLatched_nxt;

  wire logic decXtal;
  wire logic decBias;
  wire logic decPinIn;
  wire logic decHalt;
  wire logic decSup;
  wire logic decPortF;
  wire logic decPor;

  cfo_option_decode u_decode (
    .optByte(optLatched_r),
    .isXtal(decXtal),
    .biasOn(decBias),
    .pinAsInput(decPinIn),
    .haltPermit(decHalt),
    .supervisorOn(decSup),
    .portFFull(decPortF),
    .porOn(decPor)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Initialization control. A minimum hold covers the synchroniser latency
  // so the option latch sees settled fuse values before init ends.
  logic [3:0] initCnt_r;
  logic [3:0] initCnt_nxt;
  logic initActive_r;
  logic cold_r;
  logic cold_nxt;
  logic lastCold_r;
  logic lastPor_r;
  logic lastExt_r;

  wire logic extCause;
  wire logic porCause;
  wire logic anyCause;
  wire logic initActive_nxt;
  wire logic initEnding;

  assign extCause = !extRstSync_n;
  assign porCause = decPor && porSync;
  assign anyCause = extCause || porCause;
  assign initCnt_nxt = anyCause ? cfo_pkg::CFO_INIT_MIN_CYC :
                       (initCnt_r != 4'h0) ? initCnt_r - 4'h1 : 4'h0;
  assign initActive_nxt = (initCnt_nxt != 4'h0);
  assign initEnding = initActive_r && !initActive_nxt;
  assign cold_nxt = porCause ? 1'b1 : (initEnding ? 1'b0 : cold_r);
  assign optLatched_nxt = initActive_r ? optSync : optLatched_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      initCnt_r <= cfo_pkg::CFO_INIT_MIN_CYC;
      initActive_r <= 1'b1;
      cold_r <= 1'b1;
      optLatched_r <= 8'h00;
    end else if (clkEn) begin
      initCnt_r <= initCnt_nxt;
      initActive_r <= initActive_nxt;
      cold_r <= cold_nxt;
      optLatched_r <= optLatched_nxt;
    end
  end

  // Cold flag is captured when init ends; cause flags follow each active reset cause.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lastCold_r <= 1'b1;
      lastPor_r <= 1'b0;
      lastExt_r <= 1'b0;
    end else if (clkEn) begin
      if (initEnding) begin
        lastCold_r <= cold_r;
      end
      if (porCause || extCause) begin
        lastPor_r <= porCause;
        lastExt_r <= extCause;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scramble source for registers that come out of init undefined. It is
  // cheap and keeps software from relying on stale contents.
  logic [15:0] lfsr_r;
  wire logic lfsrFb;

  assign lfsrFb = lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lfsr_r <= cfo_pkg::CFO_LFSR_SEED;
    end else if (clkEn) begin
      lfsr_r <= {lfsr_r[14:0], lfsrFb};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core state registers and their initialization classes.
  logic [7:0] regFile_r [0:cfo_pkg::CFO_NREG-1];
  logic [7:0] regFile_nxt [0:cfo_pkg::CFO_NREG-1];

  genvar i;
  generate
    for (i = 0; i < cfo_pkg::CFO_NREG; i++) begin : g_reg
      localparam logic [4:0] IDX = 5'(i);
      localparam cfo_pkg::cfo_cls_t CLS = cfo_pkg::cfo_class(IDX);
      wire logic hit;
      wire logic [7:0] rnd;
      wire logic [7:0] initVal;

      assign hit = regWr && !initActive_r && (regAddr == ADDR_W'(IDX));
      assign rnd = lfsr_r[7:0] ^ {3'h0, IDX};
      assign initVal =
        (CLS == cfo_pkg::CFO_CLS_SP) ? cfo_pkg::CFO_SP_RESET :
        (CLS == cfo_pkg::CFO_CLS_RAND) ? rnd :
        (CLS == cfo_pkg::CFO_CLS_KEEP) ? (cold_r ? rnd : regFile_r[i]) :
        (CLS == cfo_pkg::CFO_CLS_XRND) ?
          ((cold_r || decXtal) ? rnd : regFile_r[i]) :
        cfo_pkg::CFO_CLEAR_VAL;
      assign regFile_nxt[i] = initActive_r ? initVal :
                              hit ? regWrData : regFile_r[i];

      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          regFile_r[i] <= cfo_pkg::CFO_CLEAR_VAL;
        end else if (clkEn) begin
          regFile_r[i] <= regFile_nxt[i];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register read port. Unmapped addresses read zero.
  wire logic [7:0] initStatus;
  wire logic [7:0] rdSel;
  logic [7:0] regRdData_r;

  assign initStatus = {4'h0, lastExt_r, lastPor_r, lastCold_r, initActive_r};
  assign rdSel =
    (regAddr < ADDR_W'(cfo_pkg::CFO_NREG)) ? regFile_r[regAddr] :
    (regAddr == ADDR_W'(cfo_pkg::CFO_IDX_INIT_STATUS)) ? initStatus : 8'h00;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData_r <= 8'h00;
    end else if (clkEn) begin
      regRdData_r <= regRd ? rdSel : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and pin controls, all registered.
  logic oscRcSel_r;
  logic xtalEnable_r;
  logic biasResEnable_r;
  logic oscPinOe_r;
  logic haltRestartIn_r;
  logic haltEnter_r;
  logic supervisorEnable_r;
  logic supErrPinOut_r;
  logic supErrPinOe_r;
  logic portFOutEn_r;
  logic portFPullEn_r;
  logic portLcgfRelease_r;
  logic portDForceHigh_r;

  wire logic oscRc;
  wire logic supErrDrive;

  assign oscRc = (optLatched_r[cfo_pkg::CFO_OPT_OSC_HI:
                  cfo_pkg::CFO_OPT_OSC_LO] == cfo_pkg::CFO_OSC_RC);
  // The error output is open drain, so it only drives while pulling low.
  assign supErrDrive = decSup && supervisorErr && !initActive_nxt;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      oscRcSel_r <= 1'b0;
      xtalEnable_r <= 1'b0;
      biasResEnable_r <= 1'b0;
      oscPinOe_r <= 1'b0;
      haltRestartIn_r <= 1'b0;
      haltEnter_r <= 1'b0;
      supervisorEnable_r <= 1'b0;
      supErrPinOut_r <= 1'b1;
      supErrPinOe_r <= 1'b0;
      portFOutEn_r <= 1'b0;
      portFPullEn_r <= 1'b0;
      portLcgfRelease_r <= 1'b0;
      portDForceHigh_r <= 1'b1;
    end else if (clkEn) begin
      oscRcSel_r <= oscRc;
      xtalEnable_r <= decXtal;
      biasResEnable_r <= decBias;
      oscPinOe_r <= decXtal;
      haltRestartIn_r <= decPinIn && oscPinSync;
      haltEnter_r <= haltReq && decHalt && !initActive_nxt;
      supervisorEnable_r <= decSup;
      supErrPinOut_r <= !supErrDrive;
      supErrPinOe_r <= supErrDrive;
      portFOutEn_r <= decPortF && !initActive_nxt;
      portFPullEn_r <= decPortF && !initActive_nxt;
      portLcgfRelease_r <= !initActive_nxt;
      portDForceHigh_r <= initActive_nxt;
    end
  end

  assign regRdData = regRdData_r;
  assign initActive = initActive_r;
  assign oscRcSel = oscRcSel_r;
  assign xtalEnable = xtalEnable_r;
  assign biasResEnable = biasResEnable_r;
  assign oscPinOe = oscPinOe_r;
  assign haltRestartIn = haltRestartIn_r;
  assign haltEnter = haltEnter_r;
  assign supervisorEnable = supervisorEnable_r;
  assign supErrPinOut = supErrPinOut_r;
  assign supErrPinOe = supErrPinOe_r;
  assign portFOutEn = portFOutEn_r;
  assign portFPullEn = portFPullEn_r;
  assign portLcgfRelease = portLcgfRelease_r;
  assign portDForceHigh = portDForceHigh_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and cover points.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  wire logic [1:0] oscCode;
  assign oscCode = optLatched_r[cfo_pkg::CFO_OPT_OSC_HI:
                                cfo_pkg::CFO_OPT_OSC_LO];

  a_osc_rc_pin: assert property (
    clkEn && oscCode == 2'h1 |=> !oscPinOe_r && oscRcSel_r && !xtalEnable_r)
    else $error("R/C mode still drives the shared clock pin");
  a_xtal_nobias: assert property (
    clkEn && oscCode == 2'h2 |=> oscPinOe_r && !biasResEnable_r)
    else $error("Crystal without bias resistor misconfigured");
  a_xtal_bias: assert property (
    clkEn && oscCode == 2'h3 |=> oscPinOe_r && biasResEnable_r)
    else $error("Crystal with bias resistor misconfigured");
  a_halt_gate: assert property (
    haltEnter_r |-> !$past(optLatched_r[0]) && $past(haltReq))
    else $error("Halt entered while option forbids it");
  a_opt_hidden: assert property (
    clkEn && !initActive_r |=> $stable(optLatched_r))
    else $error("Option byte changed outside initialization");
  a_ext_start: assert property (
    clkEn && !extRstSync_n |=> initActive_r [*3])
    else $error("Reset pin did not start initialization");
  a_ports_safe: assert property (
    initActive_r |-> portDForceHigh_r && !portLcgfRelease_r && !portFOutEn_r)
    else $error("Ports not safe during initialization");
  a_pc_clear: assert property (
    clkEn && initActive_r |=> regFile_r[16] == 8'h00 &&
                              regFile_r[17] == 8'h00)
    else $error("Program counter not cleared");
  a_ctrl_clear: assert property (
    clkEn && initActive_r |=> regFile_r[0] == 8'h00 &&
      regFile_r[1] == 8'h00 && regFile_r[2] == 8'h00 &&
      regFile_r[5] == 8'h00 && regFile_r[6] == 8'h00)
    else $error("Control registers not cleared");
  a_warm_keep: assert property (
    clkEn && initActive_r && !cold_r |=> $stable(regFile_r[8]))
    else $error("Serial shift lost on warm reset");
  a_rc_keep: assert property (
    clkEn && initActive_r && !cold_r && !decXtal |=> $stable(regFile_r[12]))
    else $error("Accumulator lost on warm R/C reset");
  a_sp_load: assert property (
    clkEn && initActive_r |=> regFile_r[11] == 8'h6f)
    else $error("Stack pointer not loaded");
  a_por_gate: assert property (
    clkEn && !initActive_r && !decPor && extRstSync_n |=> !initActive_r)
    else $error("Disabled power-on reset started init");
  a_sup_off: assert property (
    clkEn && optLatched_r[2] |=> !supErrPinOe_r && !supervisorEnable_r)
    else $error("Supervisor active while disabled");
  a_portf_off: assert property (
    clkEn && optLatched_r[1] |=> !portFOutEn_r && !portFPullEn_r)
    else $error("Port F active in reduced mode");

  c_warm_reset: cover property (initActive_r && !cold_r ##1 !initActive_r);
  c_por_reset: cover property (porCause ##[1:8] initEnding);
  c_halt: cover property (haltEnter_r);
  c_sw_write: cover property (regWr && !initActive_r ##1 regRd);

endmodule

// >>> verification/config_option_and_reset_init_test.sv
// Self-checking bench for the option-byte loader and reset initializer.
// Assumes cfo_loader and cfo_pkg are compiled first; one 250 MHz clock.
module config_option_and_reset_init_test;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  logic sysClk;
  logic resetN;
  logic clkEn;
  logic [7:0] optFuse;
  logic extRstN;
  logic porDetect;
  logic oscPin;
  logic haltReq;
  logic supErr;
  logic [4:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData;
  logic initActive, oscRcSel, xtalEnable, biasResEnable, oscPinOe;
  logic haltRestartIn, haltEnter, supervisorEnable, supErrPinOut;
  logic supErrPinOe, portFOutEn, portFPullEn, portLcgfRelease;
  logic portDForceHigh;
  int miscompares = 0;
  int totalChecks = 0;
  logic [7:0] v;
  logic [7:0] opt;
  logic [1:0] osc;
  logic [7:0] opts [5] = '{8'h08, 8'h17, 8'h1a, 8'h45, 8'h0b};

  cfo_loader cfo_loader_i (
    .sys_clk(sysClk), .reset_n(resetN), .clkEn(clkEn),
    .optFusePins(optFuse), .extResetPin_n(extRstN),
    .porDetectPin(porDetect), .oscSharedPinIn(oscPin),
    .haltReq(haltReq), .supervisorErr(supErr), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .initActive(initActive),
    .oscRcSel(oscRcSel), .xtalEnable(xtalEnable),
    .biasResEnable(biasResEnable), .oscPinOe(oscPinOe),
    .haltRestartIn(haltRestartIn), .haltEnter(haltEnter),
    .supervisorEnable(supervisorEnable), .supErrPinOut(supErrPinOut),
    .supErrPinOe(supErrPinOe), .portFOutEn(portFOutEn),
    .portFPullEn(portFPullEn), .portLcgfRelease(portLcgfRelease),
    .portDForceHigh(portDForceHigh)
  );

  initial begin
    sysClk = 1'b0;
    forever #2 sysClk = ~sysClk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sysClk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sysClk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge sysClk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sysClk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask

  // Mode outputs settle one cycle after init; the pin needs its sync lag.
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(posedge sysClk);
      #1;
      n++;
    end while (initActive !== 1'b0 && n < 40);
    chk("initActive end", initActive, 8'h00);
    repeat (3) @(posedge sysClk);
    #1;
  endtask

  task automatic pin_reset(input logic [7:0] o);
    @(posedge sysClk);
    optFuse <= o;
    extRstN <= 1'b0;
    repeat (4) @(posedge sysClk);
    #1;
    chk("initActive", initActive, 8'h01);
    chk("portDForceHigh", portDForceHigh, 8'h01);
    chk("portLcgfRelease", portLcgfRelease, 8'h00);
    chk("portFOutEn init", portFOutEn, 8'h00);
    chk("haltEnter init", haltEnter, 8'h00);
    wr(cfo_pkg::CFO_IDX_MAIN_CTRL, 8'hff);
    extRstN <= 1'b1;
    wait_idle();
  endtask

  function automatic logic [7:0] pat(input int i);
    return 8'h30 + 8'(i);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(30000 * 4);
    miscompares++;
    close_out();
  end

  initial begin
    resetN = 1'b0;
    clkEn = 1'b1;
    optFuse = 8'h08;
    extRstN = 1'b1;
    porDetect = 1'b0;
    oscPin = 1'b0;
    haltReq = 1'b0;
    supErr = 1'b0;
    regAddr = 5'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (5) @(posedge sysClk);
    resetN <= 1'b1;
    wait_idle();
    rd(cfo_pkg::CFO_IDX_STACK_PTR, v);
    chk("cold stackPtr", v, 8'h6f);
    rd(cfo_pkg::CFO_IDX_WAKE_EN, v);
    chk("cold wakeEn", v, 8'h00);
    $display("test cold reset done");
    @(posedge sysClk);
    haltReq <= 1'b1;
    supErr <= 1'b1;
    oscPin <= 1'b1;
    foreach (opts[k]) begin
      opt = opts[k];
      osc = opt[4:3];
      for (int i = 0; i < 18; i++) wr(i[4:0], pat(i));
      pin_reset(opt);
      chk("oscRcSel", oscRcSel, 8'(osc == 2'h1));
      chk("haltRestartIn", haltRestartIn, 8'(!opt[4]));
      chk("xtalEnable", xtalEnable, 8'(opt[4]));
      chk("oscPinOe", oscPinOe, 8'(opt[4]));
      chk("biasResEnable", biasResEnable, 8'(osc == 2'h3));
      chk("haltEnter", haltEnter, 8'(!opt[0]));
      chk("supervisorEnable", supervisorEnable, 8'(!opt[2]));
      chk("supErrPinOe", supErrPinOe, 8'(!opt[2]));
      chk("supErrPinOut", supErrPinOut, 8'(opt[2]));
      chk("portFOutEn", portFOutEn, 8'(!opt[1]));
      chk("portFPullEn", portFPullEn, 8'(!opt[1]));
      chk("portLcgf run", portLcgfRelease, 8'h01);
      for (int i = 0; i < 18; i++) begin
        rd(i[4:0], v);
        if (i >= 8 && i <= 10) chk($sformatf("reg%0d", i), v, pat(i));
        else if (i == 11) chk("stackPtr", v, 8'h6f);
        else if (i >= 16) chk($sformatf("pc%0d", i), v, 8'h00);
        else if (i >= 12) begin
          if (osc == 2'h1) chk($sformatf("reg%0d", i), v, pat(i));
        end
        else if (i != 7) chk($sformatf("reg%0d", i), v, 8'h00);
      end
      $display("test option %h done", opt);
    end
    // The power-on detector is ignored unless its option bit is set.
    pin_reset(8'h08);
    @(posedge sysClk);
    porDetect <= 1'b1;
    repeat (6) begin
      @(posedge sysClk);
      #1;
      chk("por off initActive", initActive, 8'h00);
    end
    @(posedge sysClk);
    porDetect <= 1'b0;
    pin_reset(8'h48);
    wr(cfo_pkg::CFO_IDX_PC_LO, 8'h05);
    @(posedge sysClk);
    porDetect <= 1'b1;
    repeat (4) @(posedge sysClk);
    #1;
    chk("por on initActive", initActive, 8'h01);
    @(posedge sysClk);
    porDetect <= 1'b0;
    wait_idle();
    rd(cfo_pkg::CFO_IDX_PC_LO, v);
    chk("por pcLo", v, 8'h00);
    $display("test power-on reset done");
    // No address reaches the option byte, so stray writes change no mode.
    for (int i = 18; i < 32; i++) wr(i[4:0], 8'hff);
    rd(5'h1f, v);
    chk("unmapped read", v, 8'h00);
    chk("xtalEnable kept", xtalEnable, 8'h00);
    chk("haltEnter kept", haltEnter, 8'h01);
    // Status index is read-only: last init was a cold power-on one.
    rd(cfo_pkg::CFO_IDX_INIT_STATUS, v);
    chk("initStatus", v, 8'h06);
    $display("test option privacy done");
    // A low clock enable freezes the reset synchroniser as well.
    @(posedge sysClk);
    clkEn <= 1'b0;
    extRstN <= 1'b0;
    repeat (6) @(posedge sysClk);
    #1;
    chk("frozen initActive", initActive, 8'h00);
    chk("frozen haltEnter", haltEnter, 8'h01);
    @(posedge sysClk);
    clkEn <= 1'b1;
    repeat (4) @(posedge sysClk);
    #1;
    chk("thawed initActive", initActive, 8'h01);
    @(posedge sysClk);
    extRstN <= 1'b1;
    wait_idle();
    $display("test clock enable done");
    close_out();
  end
endmodule
